// ### rtl/lbh_defs.svh
`ifndef LBH_DEFS_SVH
`define LBH_DEFS_SVH
// Byte lane patterns, active low (lane 3 = bits 31..24)
`define LBH_BE_NONE 4'hf
`define LBH_BE_WORD 4'h0
// Burst length field width
`define LBH_LEN_W 2
// Clock divide: internal bus clock is half the core clock
`define LBH_DIV 1'h1
`endif

// ### rtl/lbh_pkg.sv
package lbh_pkg;
   // Bus cycle states of the device end
   typedef enum logic [2:0] {
      LBH_IDLE = 3'b000,
      LBH_ADDR = 3'b001,
      LBH_DATA = 3'b010,
      LBH_WAIT = 3'b011,
      LBH_HOLD = 3'b100,
      LBH_REQ = 3'b101
   } lbh_state_t;
   // Slave end states
   typedef enum logic [1:0] {
      LBH_S_IDLE = 2'b00,
      LBH_S_XFER = 2'b01,
      LBH_S_GRANT = 2'b10
   } lbh_sstate_t;
endpackage : lbh_pkg

// ### rtl/lbh_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lbh_if;
   // Byte lanes and strobes, driven by the device
   logic [3:0] byte_lane_enables_n;
   logic [3:0] be_oe_n;
   logic address_status_strobe_n;
   logic write_nread;
   // Data bus, both drive
   logic [31:0] dev_dq_o;
   logic dev_dq_oe_n;
   logic [31:0] slv_dq_o;
   logic slv_dq_oe_n;
   // Cache / tag pin, both drive
   logic dev_ct_o;
   logic dev_ct_oe_n;
   logic slv_ct_o;
   logic slv_ct_oe_n;
   // Handshake from slave
   logic ready_n;
   // Arbitration
   logic arb_in;
   logic arb_out;
   logic arb_out_oe_n;
   // Resolved wire levels
   logic [31:0] muxed_addr_data_bus;
   logic cache_tag;
   assign muxed_addr_data_bus = !dev_dq_oe_n ? dev_dq_o : (!slv_dq_oe_n ? slv_dq_o : 32'h0);
   assign cache_tag = !dev_ct_oe_n ? dev_ct_o : (!slv_ct_oe_n ? slv_ct_o : 1'h0);
   modport dev (
      output byte_lane_enables_n, be_oe_n, address_status_strobe_n, write_nread,
      output dev_dq_o, dev_dq_oe_n, dev_ct_o, dev_ct_oe_n, arb_out, arb_out_oe_n,
      input muxed_addr_data_bus, cache_tag, ready_n, arb_in
   );
   modport far (
      output slv_dq_o, slv_dq_oe_n, slv_ct_o, slv_ct_oe_n, ready_n, arb_in,
      input byte_lane_enables_n, be_oe_n, address_status_strobe_n, write_nread,
      input muxed_addr_data_bus, cache_tag, arb_out
   );
endinterface : lbh_if
`default_nettype wire

// ### rtl/lbh_far.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbh_defs.svh"
module lbh_far
   import lbh_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Link
   lbh_if.far bus,
   // Slave user side
   input wire logic [31:0] rd_data,
   input wire logic rd_tag,
   input wire logic stall,
   output logic [31:0] wr_data,
   output logic wr_tag,
   output logic [3:0] wr_lanes,
   output logic wr_valid,
   output logic [1:0] addr_low,
   // Other master user side
   input wire logic want_bus,
   output logic has_bus
);
   // ****************************
   // Slave and master end
   // ****************************
   logic tick_r, tick_nxt;
   lbh_sstate_t st_r, st_nxt;
   logic grant_r, grant_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic wt_r, wt_nxt;
   logic [3:0] wl_r, wl_nxt;
   logic wv_r, wv_nxt;
   logic [1:0] al_r, al_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic rt_r, rt_nxt;

   // Lane pattern to low address bits
   function automatic logic [1:0] lbh_lane_addr(input logic [3:0] be_n);
      logic [1:0] a;
      a = 2'h0;
      if (!be_n[0]) a = 2'h0;
      else if (!be_n[1]) a = 2'h1;
      else if (!be_n[2]) a = 2'h2;
      else if (!be_n[3]) a = 2'h3;
      return a;
   endfunction : lbh_lane_addr

   // Next state: ready on the bus tick unless stalled
   always_comb begin
      tick_nxt = ~tick_r;
      st_nxt = st_r;
      grant_nxt = grant_r;
      wd_nxt = wd_r;
      wt_nxt = wt_r;
      wl_nxt = wl_r;
      wv_nxt = 1'h0;
      al_nxt = al_r;
      rd_nxt = rd_r;
      rt_nxt = rt_r;
      if (tick_r) begin
         grant_nxt = bus.arb_out;
         unique case (st_r)
            LBH_S_IDLE, LBH_S_GRANT: begin
               if (!bus.address_status_strobe_n) begin
                  st_nxt = LBH_S_XFER;
                  al_nxt = lbh_lane_addr(bus.byte_lane_enables_n);
                  // Load read word and tag so they stand before ready goes out
                  rd_nxt = rd_data;
                  rt_nxt = rd_tag;
               end
            end
            LBH_S_XFER: begin
               if (!stall) begin
                  if (bus.write_nread) begin
                     wd_nxt = bus.muxed_addr_data_bus;
                     wt_nxt = bus.cache_tag;
                     wl_nxt = bus.byte_lane_enables_n;
                     wv_nxt = 1'h1;
                  end
                  st_nxt = LBH_S_IDLE;
               end
            end
            default: st_nxt = LBH_S_IDLE;
         endcase
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_r <= 1'h0;
         st_r <= LBH_S_IDLE;
         grant_r <= 1'h0;
         wd_r <= 32'h0;
         wt_r <= 1'h0;
         wl_r <= `LBH_BE_NONE;
         wv_r <= 1'h0;
         al_r <= 2'h0;
         rd_r <= 32'h0;
         rt_r <= 1'h0;
      end else begin
         tick_r <= tick_nxt;
         st_r <= st_nxt;
         grant_r <= grant_nxt;
         wd_r <= wd_nxt;
         wt_r <= wt_nxt;
         wl_r <= wl_nxt;
         wv_r <= wv_nxt;
         al_r <= al_nxt;
         rd_r <= rd_nxt;
         rt_r <= rt_nxt;
      end
   end

   // Pin drive
   assign bus.ready_n = !(st_r == LBH_S_XFER && !stall);
   assign bus.slv_dq_o = rd_r;
   assign bus.slv_ct_o = rt_r;
   assign bus.slv_dq_oe_n = !(st_r == LBH_S_XFER && !bus.write_nread);
   assign bus.slv_ct_oe_n = !(st_r == LBH_S_XFER && !bus.write_nread);
   assign bus.arb_in = want_bus;
   assign has_bus = grant_r;
   assign wr_data = wd_r;
   assign wr_tag = wt_r;
   assign wr_lanes = wl_r;
   assign wr_valid = wv_r;
   assign addr_low = al_r;
endmodule : lbh_far
`default_nettype wire

// ### rtl/lbh_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbh_defs.svh"
// Summary of operation
// - Four active-low byte lanes, lane3 = top byte
// - Address state lanes qualify first word
// - Data state lanes qualify the next word
// - Lanes before final ready are undefined
// - Lanes held while ready stays deasserted
// - Read lanes mark exactly bytes consumed
// - At least one lane, contiguous only
// - Only naturally aligned lane patterns
// - Far side decodes low address bits
// - Primary grants hold: float, acknowledge, hold
// - Request withdrawn: drop acknowledge, idle/address
// - Role fixed at initialization
// - Secondary requests; grant input means ownership
// - Cache indication driven in address state
// - Cache pin floats when bus idle
// - Tag per word; writer drives it
// - Slave ready ends data, else waits
// - Burst re-asserts address strobe after ready
module lbh_dev
   import lbh_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Link
   lbh_if.dev bus,
   // Role strap, sampled after reset release
   input wire logic primary_in,
   // Request from core
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [29:0] req_word_addr,
   input wire logic [1:0] req_byte_addr,
   input wire logic [1:0] req_size,
   input wire logic [1:0] req_len,
   input wire logic req_cacheable,
   input wire logic [31:0] wr_data,
   input wire logic wr_tag,
   output logic req_ready,
   // Answer to core
   output logic [31:0] rd_data,
   output logic rd_tag,
   output logic rd_valid,
   output logic word_done,
   output logic owns_bus
);
   // ****************************
   // Lane encode
   // ****************************
   // Size 0 byte, 1 halfword, 2 word; aligned patterns only
   function automatic logic [3:0] lbh_lanes(input logic [1:0] sz, input logic [1:0] ba);
      logic [3:0] m;
      m = `LBH_BE_NONE;
      unique case (sz)
         2'h0: m = ~(4'h1 << ba);
         2'h1: m = ba[1] ? 4'h3 : 4'hc;
         default: m = `LBH_BE_WORD;
      endcase
      return m;
   endfunction : lbh_lanes

   // ****************************
   // State
   // ****************************
   logic tick_r, tick_nxt;
   logic cfg_r, cfg_nxt;
   logic prim_r, prim_nxt;
   lbh_state_t st_r, st_nxt;
   logic [3:0] be_r, be_nxt;
   logic [1:0] left_r, left_nxt;
   logic ads_r, ads_nxt;
   logic wr_r, wr_nxt;
   logic cache_r, cache_nxt;
   logic [31:0] dq_r, dq_nxt;
   logic tag_r, tag_nxt;
   logic [1:0] sz_r, sz_nxt;
   logic [3:0] mask_r, mask_nxt;
   logic [31:0] rdd_r, rdd_nxt;
   logic rdt_r, rdt_nxt;
   logic rdv_r, rdv_nxt;
   logic done_r, done_nxt;
   logic arb_r, arb_nxt;
   logic [31:0] rmask;
   logic rdy;
   logic start;

   assign rdy = !bus.ready_n;
   assign start = tick_r && req_valid && (st_r == LBH_IDLE) && cfg_r
                  && (prim_r ? !bus.arb_in : bus.arb_in);

   // Read byte mask from lanes
   generate
      for (genvar g = 0; g < 4; g++) begin : g_mask
         assign rmask[8*g+7:8*g] = {8{~mask_r[g]}};
      end
   endgenerate

   // Next state: one bus cycle per tick
   always_comb begin
      tick_nxt = ~tick_r;
      cfg_nxt = 1'h1;
      prim_nxt = cfg_r ? prim_r : primary_in;
      st_nxt = st_r;
      be_nxt = be_r;
      left_nxt = left_r;
      ads_nxt = ads_r;
      wr_nxt = wr_r;
      cache_nxt = cache_r;
      dq_nxt = dq_r;
      tag_nxt = tag_r;
      sz_nxt = sz_r;
      mask_nxt = mask_r;
      rdd_nxt = rdd_r;
      rdt_nxt = rdt_r;
      rdv_nxt = 1'h0;
      done_nxt = 1'h0;
      arb_nxt = arb_r;
      if (tick_r && cfg_r) begin
         unique case (st_r)
            LBH_IDLE: begin
               arb_nxt = prim_r ? 1'h0 : req_valid;
               if (start) begin
                  st_nxt = LBH_ADDR;
                  be_nxt = lbh_lanes(req_size, req_byte_addr);
                  mask_nxt = be_nxt;
                  sz_nxt = req_size;
                  left_nxt = req_len;
                  wr_nxt = req_write;
                  cache_nxt = req_cacheable;
                  dq_nxt = {req_word_addr, req_len};
                  ads_nxt = 1'h1;
               end else if (prim_r && bus.arb_in) begin
                  st_nxt = LBH_HOLD;
                  arb_nxt = 1'h1;
               end
            end
            LBH_ADDR: begin
               st_nxt = LBH_DATA;
               ads_nxt = 1'h0;
               dq_nxt = wr_r ? wr_data : 32'h0;
               tag_nxt = wr_r ? wr_tag : 1'h0;
               // Next word lanes; undefined unless it is the last
               be_nxt = (left_r == 2'h0) ? be_r : `LBH_BE_WORD;
            end
            LBH_DATA, LBH_WAIT: begin
               ads_nxt = 1'h0;
               if (rdy) begin
                  done_nxt = 1'h1;
                  mask_nxt = be_r;
                  rdv_nxt = !wr_r;
                  rdd_nxt = bus.muxed_addr_data_bus & rmask;
                  rdt_nxt = bus.cache_tag;
                  if (left_r == 2'h0) begin
                     st_nxt = LBH_IDLE;
                     be_nxt = `LBH_BE_NONE;
                  end else begin
                     st_nxt = LBH_DATA;
                     left_nxt = left_r - 2'h1;
                     ads_nxt = 1'h1;
                     dq_nxt = wr_r ? wr_data : 32'h0;
                     tag_nxt = wr_r ? wr_tag : 1'h0;
                  end
               end else begin
                  st_nxt = LBH_WAIT;
               end
            end
            LBH_HOLD: begin
               if (!bus.arb_in) begin
                  st_nxt = LBH_IDLE;
                  arb_nxt = 1'h0;
               end
            end
            default: st_nxt = LBH_IDLE;
         endcase
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_r <= 1'h0;
         cfg_r <= 1'h0;
         prim_r <= 1'h1;
         st_r <= LBH_IDLE;
         be_r <= `LBH_BE_NONE;
         left_r <= 2'h0;
         ads_r <= 1'h0;
         wr_r <= 1'h0;
         cache_r <= 1'h0;
         dq_r <= 32'h0;
         tag_r <= 1'h0;
         sz_r <= 2'h0;
         mask_r <= `LBH_BE_NONE;
         rdd_r <= 32'h0;
         rdt_r <= 1'h0;
         rdv_r <= 1'h0;
         done_r <= 1'h0;
         arb_r <= 1'h0;
      end else begin
         tick_r <= tick_nxt;
         cfg_r <= cfg_nxt;
         prim_r <= prim_nxt;
         st_r <= st_nxt;
         be_r <= be_nxt;
         left_r <= left_nxt;
         ads_r <= ads_nxt;
         wr_r <= wr_nxt;
         cache_r <= cache_nxt;
         dq_r <= dq_nxt;
         tag_r <= tag_nxt;
         sz_r <= sz_nxt;
         mask_r <= mask_nxt;
         rdd_r <= rdd_nxt;
         rdt_r <= rdt_nxt;
         rdv_r <= rdv_nxt;
         done_r <= done_nxt;
         arb_r <= arb_nxt;
      end
   end

   // ****************************
   // Pin drive
   // ****************************
   logic active;
   assign active = (st_r == LBH_ADDR) || (st_r == LBH_DATA) || (st_r == LBH_WAIT);
   assign bus.byte_lane_enables_n = be_r;
   assign bus.be_oe_n = {4{!active}};
   assign bus.address_status_strobe_n = !ads_r;
   assign bus.write_nread = wr_r;
   assign bus.dev_dq_o = dq_r;
   assign bus.dev_dq_oe_n = !((st_r == LBH_ADDR) || (active && wr_r));
   assign bus.dev_ct_o = (st_r == LBH_ADDR) ? cache_r : tag_r;
   assign bus.dev_ct_oe_n = !((st_r == LBH_ADDR) || (active && wr_r));
   assign bus.arb_out = arb_r;
   assign bus.arb_out_oe_n = 1'h0;
   // Core side
   assign req_ready = start;
   assign rd_data = rdd_r;
   assign rd_tag = rdt_r;
   assign rd_valid = rdv_r;
   assign word_done = done_r;
   assign owns_bus = prim_r ? (st_r != LBH_HOLD) : bus.arb_in;
endmodule : lbh_dev
`default_nettype wire

// ### tb/lbh_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Link checker
// ****
module lbh_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Device side of the link
   input wire logic [3:0] byte_lane_enables_n,
   input wire logic [3:0] be_oe_n,
   input wire logic address_status_strobe_n,
   input wire logic write_nread,
   input wire logic dev_dq_oe_n,
   input wire logic dev_ct_oe_n,
   input wire logic arb_out,
   // Far side of the link
   input wire logic slv_ct_oe_n,
   input wire logic ready_n,
   input wire logic arb_in
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Lanes driven by the device
   wire logic drv = (be_oe_n != 4'hf);
   lanes_legal_a: assert property (drv |-> byte_lane_enables_n inside
      {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0}) else $error("illegal lane pattern");
   addr_lanes_a: assert property (!address_status_strobe_n |-> drv)
      else $error("lanes not driven in address state");
   lane_hold_a: assert property (drv && address_status_strobe_n && ready_n
      |=> $stable(byte_lane_enables_n)) else $error("lanes moved while waiting");
   read_float_a: assert property (drv && !write_nread && address_status_strobe_n
      |-> dev_dq_oe_n && dev_ct_oe_n) else $error("device drives read data");
   cache_idle_a: assert property (be_oe_n == 4'hf |-> dev_ct_oe_n)
      else $error("cache pin driven while idle");
   cache_addr_a: assert property (!address_status_strobe_n && $past(be_oe_n) == 4'hf
      |-> !dev_ct_oe_n) else $error("cache pin not driven in address state");
   hold_float_a: assert property ($rose(arb_out) |-> (be_oe_n == 4'hf
      && dev_dq_oe_n && dev_ct_oe_n) [*2]) else $error("outputs not floated");
   hold_drop_a: assert property (arb_out && $fell(arb_in) |-> ##[0:4] !arb_out)
      else $error("acknowledge not dropped");
   hold_edge_a: assert property ($rose(arb_out) |-> $past(be_oe_n, 2) == 4'hf)
      else $error("bus granted mid transfer");
endmodule : lbh_chk
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench top
// ****
module tb;
   import lbh_pkg::*;
   logic core_clk, rstn, primary_in, req_valid, req_write, req_cacheable, wr_tag, rt_in;
   logic stall, want_bus, req_ready, rd_tag, rd_valid, word_done, owns_bus, f_wt, f_wv, has_bus;
   logic [29:0] req_word_addr;
   logic [1:0] req_byte_addr, req_size, req_len, addr_low, b, s;
   logic [31:0] wr_data, rd_in, rd_data, f_wd;
   logic [34:0] rq[$], wq[$];
   logic [3:0] lq[$];
   logic [3:0] f_wl;
   int fail_count, comparisons, cyc, dn, seed, k, j;
   lbh_if bus_if();
   lbh_dev lbh_dev_i (.core_clk(core_clk), .rstn(rstn), .bus(bus_if), .primary_in(primary_in),
      .req_valid(req_valid), .req_write(req_write), .req_word_addr(req_word_addr),
      .req_byte_addr(req_byte_addr), .req_size(req_size), .req_len(req_len),
      .req_cacheable(req_cacheable), .wr_data(wr_data), .wr_tag(wr_tag), .req_ready(req_ready),
      .rd_data(rd_data), .rd_tag(rd_tag), .rd_valid(rd_valid), .word_done(word_done),
      .owns_bus(owns_bus));
   lbh_far lbh_far_i (.core_clk(core_clk), .rstn(rstn), .bus(bus_if), .rd_data(rd_in),
      .rd_tag(rt_in), .stall(stall), .wr_data(f_wd), .wr_tag(f_wt), .wr_lanes(f_wl),
      .wr_valid(f_wv), .addr_low(addr_low), .want_bus(want_bus), .has_bus(has_bus));
   lbh_chk lbh_chk_i (.core_clk(core_clk), .rstn(rstn),
      .byte_lane_enables_n(bus_if.byte_lane_enables_n), .be_oe_n(bus_if.be_oe_n),
      .address_status_strobe_n(bus_if.address_status_strobe_n), .write_nread(bus_if.write_nread),
      .dev_dq_oe_n(bus_if.dev_dq_oe_n), .dev_ct_oe_n(bus_if.dev_ct_oe_n), .arb_out(bus_if.arb_out),
      .slv_ct_oe_n(bus_if.slv_ct_oe_n), .ready_n(bus_if.ready_n), .arb_in(bus_if.arb_in));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // Result watcher and timeout
   always @(posedge core_clk) begin
      cyc++;
      if (word_done === 1'b1) dn++;
      if (rd_valid === 1'b1) chk("rd", {2'h0, rd_tag, rd_data}, rq.size() ? rq.pop_front() : '1);
      if (f_wv === 1'b1) chk("wr", {addr_low, f_wt, f_wd}, wq.size() ? wq.pop_front() : '1);
      if (f_wv === 1'b1) chk("lanes", {31'h0, f_wl}, lq.size() ? {31'h0, lq.pop_front()} : '1);
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // Random stalls from the slave
   always @(negedge core_clk) stall <= ($random(seed) & 3) == 0;
   task automatic do_reset(input logic p);
      rstn = 1'b0;
      primary_in = p;
      repeat (12) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask : do_reset
   // One request, expected words noted before it is issued
   task automatic xfer(input logic w, input logic [1:0] ba, input logic [1:0] sz,
      input logic [1:0] ln);
      logic [3:0] l;
      logic [1:0] al;
      int i;
      int t;
      l = sz == 2'h0 ? ~(4'h1 << ba) : (sz == 2'h1 ? ~(4'h3 << {ba[1], 1'b0}) : 4'h0);
      al = sz == 2'h0 ? ba : (sz == 2'h1 ? {ba[1], 1'b0} : 2'h0);
      {req_write, req_byte_addr, req_size, req_len} = {w, ba, sz, ln};
      req_word_addr = 30'($random(seed));
      {req_cacheable, wr_tag, rt_in} = 3'($random(seed));
      wr_data = $random(seed);
      rd_in = $random(seed);
      for (i = 0; i <= ln; i++) begin
         if (w) begin
            wq.push_back({al, wr_tag, wr_data});
            lq.push_back(l);
         end else rq.push_back({2'h0, rt_in, rd_in & {{8{~l[3]}}, {8{~l[2]}}, {8{~l[1]}}, {8{~l[0]}}}});
      end
      t = dn + ln + 1;
      req_valid = 1'b1;
      #1;
      for (i = 0; req_ready !== 1'b1 && i < 80; i++) begin
         @(negedge core_clk);
         #1;
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      for (i = 0; dn < t && i < 300; i++) @(negedge core_clk);
      repeat (4) @(negedge core_clk);
   endtask : xfer
   // Main sequence
   initial begin
      seed = 32'h4999f820;
      {rstn, primary_in, req_valid, req_write, req_cacheable, wr_tag, rt_in, stall} = '0;
      {want_bus, req_word_addr, req_byte_addr, req_size, req_len, wr_data, rd_in} = '0;
      {fail_count, comparisons, cyc, dn} = '0;
      do_reset(1'b1);
      // Every size and burst length, random lane positions, both directions
      for (k = 0; k < 64; k++) begin
         s = k[1:0];
         b = 2'($random(seed)) & (s[1] ? 2'h0 : {1'b1, ~s[0]});
         xfer(k[2], b, s, s[1] ? 2'(k >> 3) : 2'h0);
      end
      // Hold requested mid burst, granted only after it
      fork
         xfer(1'b0, 2'h0, 2'h2, 2'h3);
         begin
            repeat (5) @(negedge core_clk);
            want_bus = 1'b1;
         end
      join
      repeat (6) @(negedge core_clk);
      chk("hold", {has_bus, owns_bus}, 35'h2);
      // Requests refused while the bus is lent out
      req_valid = 1'b1;
      for (j = 0; j < 8; j++) begin
         @(negedge core_clk);
         chk("refused", req_ready, 35'h0);
      end
      req_valid = 1'b0;
      want_bus = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("release", has_bus, 35'h0);
      // Secondary role, strap change after reset ignored
      do_reset(1'b0);
      primary_in = 1'b1;
      fork
         xfer(1'b1, 2'h0, 2'h2, 2'h1);
         begin
            repeat (8) @(negedge core_clk);
            chk("request", {has_bus, req_ready}, 35'h2);
            want_bus = 1'b1;
         end
      join
      want_bus = 1'b0;
      // Read waits for the grant that follows its own request
      fork
         xfer(1'b0, 2'h0, 2'h2, 2'h0);
         begin
            repeat (4) @(negedge core_clk);
            want_bus = 1'b1;
         end
      join
      want_bus = 1'b0;
      repeat (8) @(negedge core_clk);
      chk("pending", rq.size() + wq.size() + lq.size(), 35'h0);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
